/* File: common/acc_pkg.sv */
// constants for the analog column configuration register bank
// How it works
// - continuous-time bit 1 clear: range reaches ground rail only; set: rail-to-rail
// - continuous-time bit 0 clear powers the column off; set enables it
// - switched-capacitor bit 7 picks 16 feedback units when clear, 32 when set
// - bit 6 set swaps internal clock phases and comparator capture and output events
// - bit 5 set swaps input and reference sampling phases, making gain negative
// - bits 4 to 0 hold a binary input capacitor code, 32 sizes
// - type E bit 7 clear integrates slowly and accurately; set integrates fast
package acc_pkg;

  // ==========================================================================
  // bus geometry
  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned IDX_W   = 10;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned REG_W   = 8;

  // ==========================================================================
  // register indices; byte address is four times the index
  localparam int unsigned NUM_CT  = 2;
  localparam int unsigned NUM_SE  = 2;
  localparam int unsigned NUM_SCC = 4;

  localparam logic [IDX_W-1:0] IDX_CT_C0   = 10'h073;
  localparam logic [IDX_W-1:0] IDX_CT_C1   = 10'h077;
  localparam logic [IDX_W-1:0] IDX_SE_R1C0 = 10'h080;
  localparam logic [IDX_W-1:0] IDX_SE_R1C1 = 10'h084;
  localparam logic [IDX_W-1:0] IDX_SC_R1C0 = 10'h080;
  localparam logic [IDX_W-1:0] IDX_SC_R1C2 = 10'h088;
  localparam logic [IDX_W-1:0] IDX_SC_R2C1 = 10'h094;
  localparam logic [IDX_W-1:0] IDX_SC_R2C3 = 10'h09C;

  localparam logic [NUM_CT-1:0][IDX_W-1:0]  IDX_CT  = {IDX_CT_C1, IDX_CT_C0};
  localparam logic [NUM_SE-1:0][IDX_W-1:0]  IDX_SE  = {IDX_SE_R1C1, IDX_SE_R1C0};
  localparam logic [NUM_SCC-1:0][IDX_W-1:0] IDX_SCC = {IDX_SC_R2C3, IDX_SC_R2C1,
                                                       IDX_SC_R1C2, IDX_SC_R1C0};

  // ==========================================================================
  // field positions
  localparam int unsigned CT_PWR_BIT   = 0;
  localparam int unsigned CT_RAIL_BIT  = 1;
  localparam int unsigned SC_INPUT_CAP_CODE_LSB  = 0;
  localparam int unsigned SC_INPUT_CAP_CODE_W    = 5;
  localparam int unsigned SC_SIGN_BIT  = 5;
  localparam int unsigned SC_PHASE_BIT = 6;
  localparam int unsigned SC_FEEDBACK_CAP_SIZE_BIT  = 7;
  localparam int unsigned SE_SPEED_BIT = 7;

  // ==========================================================================
  // implemented-bit masks and reset value
  localparam logic [REG_W-1:0] CT_MASK   = 8'h03;
  localparam logic [REG_W-1:0] SE_MASK   = 8'h80;
  localparam logic [REG_W-1:0] SC_MASK   = 8'hFF;
  localparam logic [REG_W-1:0] REG_RESET = 8'h00;

endpackage : acc_pkg

/* File: hw/acc_regs.sv */
// APB register bank driving analog column configuration outputs
//
// Design decision made here: the APB interface to the registers.
module acc_regs #(
  // 1: index 0x80 is the type E switched-capacitor register; 0: type C
  parameter bit TYPE_E_MAP = 1'b1
) (
  // clock and reset
  input  wire logic                                   clock_i,
  input  wire logic                                   rst_i,
  // apb slave
  input  wire logic                                   psel_i,
  input  wire logic                                   penable_i,
  input  wire logic                                   pwrite_i,
  input  wire logic [acc_pkg::ADDR_W-1:0]             paddr_i,
  input  wire logic [acc_pkg::DATA_W-1:0]             pwdata_i,
  input  wire logic [acc_pkg::DATA_W/8-1:0]           pstrb_i,
  output logic      [acc_pkg::DATA_W-1:0]             prdata_o,
  output logic                                        pready_o,
  output logic                                        pslverr_o,
  // continuous-time column controls
  output logic      [acc_pkg::NUM_CT-1:0]             rail_to_rail_sel_o,
  output logic      [acc_pkg::NUM_CT-1:0]             column_power_on_o,
  // type E switched-capacitor controls
  output logic      [acc_pkg::NUM_SE-1:0]             integration_speed_sel_o,
  // type C switched-capacitor controls
  output logic      [acc_pkg::NUM_SCC-1:0]            feedback_cap_size_o,
  output logic      [acc_pkg::NUM_SCC-1:0]            phase_swap_sel_o,
  output logic      [acc_pkg::NUM_SCC-1:0]            gain_sign_sel_o,
  output logic      [acc_pkg::NUM_SCC-1:0][acc_pkg::SC_INPUT_CAP_CODE_W-1:0] input_cap_code_o
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [acc_pkg::NUM_CT-1:0][acc_pkg::REG_W-1:0]  cte;
    logic [acc_pkg::NUM_SE-1:0][acc_pkg::REG_W-1:0]  see;
    logic [acc_pkg::NUM_SCC-1:0][acc_pkg::REG_W-1:0] scc;
    logic [acc_pkg::DATA_W-1:0]                      prdata;
    logic                                            pready;
    logic                                            pslverr;
  } acc_state_s;

  acc_state_s                   st;
  acc_state_s                   next_st;
  logic [acc_pkg::IDX_W-1:0]    idx;
  logic                         access;
  logic                         wr_go;
  logic                         hit;
  logic [acc_pkg::REG_W-1:0]    rd_data;

  assign idx    = paddr_i[acc_pkg::ADDR_W-1:acc_pkg::IDX_LSB];
  assign access = psel_i & penable_i;
  // writes land only at the edge where the completed access is sampled
  assign wr_go  = access & st.pready & pwrite_i & pstrb_i[0];

  // ==========================================================================
  // decode and next state
  always_comb begin
    next_st = st;
    hit     = 1'b0;
    rd_data = acc_pkg::REG_RESET;
    for (int i = 0; i < acc_pkg::NUM_CT; i++) begin
      if (idx == acc_pkg::IDX_CT[i]) begin
        hit     = 1'b1;
        rd_data = st.cte[i];
        if (wr_go) begin
          next_st.cte[i] = pwdata_i[acc_pkg::REG_W-1:0] & acc_pkg::CT_MASK;
        end
      end
    end
    for (int i = 0; i < acc_pkg::NUM_SE; i++) begin
      if (TYPE_E_MAP && idx == acc_pkg::IDX_SE[i]) begin
        hit     = 1'b1;
        rd_data = st.see[i];
        if (wr_go) begin
          next_st.see[i] = pwdata_i[acc_pkg::REG_W-1:0] & acc_pkg::SE_MASK;
        end
      end
    end
    // a type C slot sharing its index with a type E one is hidden in type E mode
    for (int i = 0; i < acc_pkg::NUM_SCC; i++) begin
      if (idx == acc_pkg::IDX_SCC[i] &&
          !(TYPE_E_MAP && acc_pkg::IDX_SCC[i] == acc_pkg::IDX_SE[0])) begin
        hit     = 1'b1;
        rd_data = st.scc[i];
        if (wr_go) begin
          next_st.scc[i] = pwdata_i[acc_pkg::REG_W-1:0] & acc_pkg::SC_MASK;
        end
      end
    end
    // one wait state, then a single-cycle ready
    next_st.pready  = access & ~st.pready;
    next_st.pslverr = access & ~st.pready & ~hit;
    if (access && !st.pready) begin
      next_st.prdata = {{(acc_pkg::DATA_W-acc_pkg::REG_W){1'b0}}, rd_data};
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // outputs, all straight from the register bits
  assign prdata_o  = st.prdata;
  assign pready_o  = st.pready;
  assign pslverr_o = st.pslverr;

  genvar g;
  generate
    for (g = 0; g < acc_pkg::NUM_CT; g++) begin : g_ct
      assign rail_to_rail_sel_o[g] = st.cte[g][acc_pkg::CT_RAIL_BIT];
      assign column_power_on_o[g]  = st.cte[g][acc_pkg::CT_PWR_BIT];
    end
    for (g = 0; g < acc_pkg::NUM_SE; g++) begin : g_se
      assign integration_speed_sel_o[g] = st.see[g][acc_pkg::SE_SPEED_BIT];
    end
    // phase and sign swaps are decoded by the analog switch drivers downstream
    for (g = 0; g < acc_pkg::NUM_SCC; g++) begin : g_sc
      assign feedback_cap_size_o[g] = st.scc[g][acc_pkg::SC_FEEDBACK_CAP_SIZE_BIT];
      assign phase_swap_sel_o[g]    = st.scc[g][acc_pkg::SC_PHASE_BIT];
      assign gain_sign_sel_o[g]     = st.scc[g][acc_pkg::SC_SIGN_BIT];
      assign input_cap_code_o[g]    =
        st.scc[g][acc_pkg::SC_INPUT_CAP_CODE_LSB +: acc_pkg::SC_INPUT_CAP_CODE_W];
    end
  endgenerate

  // ==========================================================================
  // assertions
  logic wr_ct0;
  logic wr_ct1;
  logic wr_se1;
  logic wr_sc2;
  assign wr_ct0 = wr_go && idx == acc_pkg::IDX_CT[0];
  assign wr_ct1 = wr_go && idx == acc_pkg::IDX_CT[1];
  assign wr_se1 = wr_go && idx == acc_pkg::IDX_SE[1];
  assign wr_sc2 = wr_go && idx == acc_pkg::IDX_SC_R1C2;

  rail_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
    wr_ct1 |=> rail_to_rail_sel_o[1] == $past(pwdata_i[acc_pkg::CT_RAIL_BIT]))
    else $error("rail-to-rail select did not follow write");

  power_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
    wr_ct0 |=> column_power_on_o[0] == $past(pwdata_i[acc_pkg::CT_PWR_BIT]))
    else $error("column power did not follow write");

  feedback_cap_size_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
    wr_sc2 |=> feedback_cap_size_o[1] == $past(pwdata_i[acc_pkg::SC_FEEDBACK_CAP_SIZE_BIT]))
    else $error("feedback cap size did not follow write");

  phase_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
    wr_sc2 |=> phase_swap_sel_o[1] == $past(pwdata_i[acc_pkg::SC_PHASE_BIT]))
    else $error("phase swap did not follow write");

  sign_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
    wr_sc2 |=> gain_sign_sel_o[1] == $past(pwdata_i[acc_pkg::SC_SIGN_BIT]))
    else $error("gain sign did not follow write");

  input_cap_code_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !wr_sc2 |=> $stable(input_cap_code_o[1]))
    else $error("input cap code changed without write");

  speed_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (TYPE_E_MAP && wr_se1) |=>
      integration_speed_sel_o[1] == $past(pwdata_i[acc_pkg::SE_SPEED_BIT]))
    else $error("integration speed did not follow write");

  reset_clear_a: assert property (@(posedge clock_i)
    rst_i |=> (column_power_on_o == '0 && rail_to_rail_sel_o == '0 &&
               integration_speed_sel_o == '0 && input_cap_code_o == '0 &&
               feedback_cap_size_o == '0 && !pready_o))
    else $error("controls not cleared after reset");

  reserved_zero_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (access && !pready_o && !pwrite_i && idx == acc_pkg::IDX_CT[0]) |=>
      (pready_o && prdata_o[acc_pkg::DATA_W-1:acc_pkg::CT_RAIL_BIT+1] == '0))
    else $error("reserved bits read non-zero");

  ready_once_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (access && !pready_o) |=> pready_o ##1 !pready_o)
    else $error("ready not a single pulse after one wait");

  wr_ct0_c: cover property (@(posedge clock_i) disable iff (rst_i)
    wr_ct0 && pwdata_i[acc_pkg::CT_PWR_BIT]);
  wr_sc_c: cover property (@(posedge clock_i) disable iff (rst_i) wr_sc2);
  rd_err_c: cover property (@(posedge clock_i) disable iff (rst_i) pready_o && pslverr_o);
  b2b_c: cover property (@(posedge clock_i) disable iff (rst_i)
    pready_o ##1 (psel_i && !penable_i));

  // ==========================================================================
  // per-register checks; each slot follows its own write and holds otherwise
  logic [acc_pkg::NUM_CT-1:0]  wr_ct_hit;
  logic [acc_pkg::NUM_SE-1:0]  wr_se_hit;
  logic [acc_pkg::NUM_SCC-1:0] wr_sc_hit;

  for (g = 0; g < acc_pkg::NUM_CT; g++) begin : g_ct_chk
    assign wr_ct_hit[g] = wr_go && idx == acc_pkg::IDX_CT[g];

    ct_follow_a: assert property (@(posedge clock_i) disable iff (rst_i)
      wr_ct_hit[g] |=>
        rail_to_rail_sel_o[g] == $past(pwdata_i[acc_pkg::CT_RAIL_BIT]) &&
        column_power_on_o[g] == $past(pwdata_i[acc_pkg::CT_PWR_BIT]))
      else $error("column control did not follow its write");

    ct_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
      !wr_ct_hit[g] |=> $stable(rail_to_rail_sel_o[g]) && $stable(column_power_on_o[g]))
      else $error("column control changed without a write");

    ct_read_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (access && !pready_o && !pwrite_i && idx == acc_pkg::IDX_CT[g]) |=>
        prdata_o == {{(acc_pkg::DATA_W-acc_pkg::REG_W){1'b0}}, st.cte[g]})
      else $error("column register read back wrong");

    ct_resv_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (st.cte[g] & ~acc_pkg::CT_MASK) == '0)
      else $error("reserved column register bit stored");
  end

  // with the type C mapping both type E slots are unmapped and keep their reset value
  for (g = 0; g < acc_pkg::NUM_SE; g++) begin : g_se_chk
    assign wr_se_hit[g] = TYPE_E_MAP && wr_go && idx == acc_pkg::IDX_SE[g];

    se_follow_a: assert property (@(posedge clock_i) disable iff (rst_i)
      wr_se_hit[g] |=> integration_speed_sel_o[g] == $past(pwdata_i[acc_pkg::SE_SPEED_BIT]))
      else $error("integration speed did not follow its write");

    se_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
      !wr_se_hit[g] |=> $stable(integration_speed_sel_o[g]))
      else $error("integration speed changed without a write");

    se_read_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (TYPE_E_MAP && access && !pready_o && !pwrite_i && idx == acc_pkg::IDX_SE[g]) |=>
        prdata_o == {{(acc_pkg::DATA_W-acc_pkg::REG_W){1'b0}}, st.see[g]})
      else $error("type E register read back wrong");

    se_resv_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (st.see[g] & ~acc_pkg::SE_MASK) == '0)
      else $error("reserved type E register bit stored");
  end

  // the slot hidden by the type E mapping never sees a write, so it must stay zero
  for (g = 0; g < acc_pkg::NUM_SCC; g++) begin : g_sc_chk
    assign wr_sc_hit[g] = wr_go && idx == acc_pkg::IDX_SCC[g] &&
                          !(TYPE_E_MAP && acc_pkg::IDX_SCC[g] == acc_pkg::IDX_SE[0]);

    sc_follow_a: assert property (@(posedge clock_i) disable iff (rst_i)
      wr_sc_hit[g] |=>
        input_cap_code_o[g] == $past(pwdata_i[acc_pkg::SC_INPUT_CAP_CODE_LSB +: acc_pkg::SC_INPUT_CAP_CODE_W]) &&
        feedback_cap_size_o[g] == $past(pwdata_i[acc_pkg::SC_FEEDBACK_CAP_SIZE_BIT]) &&
        phase_swap_sel_o[g] == $past(pwdata_i[acc_pkg::SC_PHASE_BIT]) &&
        gain_sign_sel_o[g] == $past(pwdata_i[acc_pkg::SC_SIGN_BIT]))
      else $error("capacitor controls did not follow their write");

    sc_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
      !wr_sc_hit[g] |=> $stable(input_cap_code_o[g]) && $stable(feedback_cap_size_o[g]) &&
        $stable(phase_swap_sel_o[g]) && $stable(gain_sign_sel_o[g]))
      else $error("capacitor controls changed without a write");

    sc_read_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (access && !pready_o && !pwrite_i && idx == acc_pkg::IDX_SCC[g] &&
       !(TYPE_E_MAP && acc_pkg::IDX_SCC[g] == acc_pkg::IDX_SE[0])) |=>
        prdata_o == {{(acc_pkg::DATA_W-acc_pkg::REG_W){1'b0}}, st.scc[g]})
      else $error("capacitor register read back wrong");
  end

  // ==========================================================================
  // bus-level checks
  err_with_ready_a: assert property (@(posedge clock_i) disable iff (rst_i)
    pslverr_o |-> pready_o)
    else $error("error flag raised outside a ready cycle");

  err_one_cycle_a: assert property (@(posedge clock_i) disable iff (rst_i)
    pslverr_o |=> !pslverr_o)
    else $error("error flag held longer than one cycle");

  miss_err_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (access && !pready_o && !hit) |=> (pready_o && pslverr_o))
    else $error("unmapped access not answered with an error");

  hit_ok_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (access && !pready_o && hit) |=> !pslverr_o)
    else $error("mapped access answered with an error");

  idle_quiet_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !access |=> !pready_o)
    else $error("ready raised without an access");

  upper_zero_a: assert property (@(posedge clock_i) disable iff (rst_i)
    prdata_o[acc_pkg::DATA_W-1:acc_pkg::REG_W] == '0)
    else $error("read data above the register byte not zero");

  miss_data_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (pready_o && pslverr_o) |-> prdata_o == '0)
    else $error("unmapped read returned data");

  prdata_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !(access && !pready_o) |=> $stable(prdata_o))
    else $error("read data changed outside a wait state");

  // controls move only at the ready edge of a mapped, strobed write
  wait_no_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (access && !pready_o) |=>
    $stable(rail_to_rail_sel_o) && $stable(column_power_on_o) &&
    $stable(integration_speed_sel_o) && $stable(feedback_cap_size_o) &&
    $stable(phase_swap_sel_o) && $stable(gain_sign_sel_o) && $stable(input_cap_code_o))
    else $error("controls changed in a wait state");

  strobe_off_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (access && pready_o && pwrite_i && !pstrb_i[0]) |=>
    $stable(rail_to_rail_sel_o) && $stable(column_power_on_o) &&
    $stable(integration_speed_sel_o) && $stable(feedback_cap_size_o) &&
    $stable(phase_swap_sel_o) && $stable(gain_sign_sel_o) && $stable(input_cap_code_o))
    else $error("write without byte strobe changed controls");

  read_no_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (access && pready_o && !pwrite_i) |=>
    $stable(rail_to_rail_sel_o) && $stable(column_power_on_o) &&
    $stable(integration_speed_sel_o) && $stable(feedback_cap_size_o) &&
    $stable(phase_swap_sel_o) && $stable(gain_sign_sel_o) && $stable(input_cap_code_o))
    else $error("read changed controls");

  miss_no_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (access && pready_o && pslverr_o) |=>
    $stable(rail_to_rail_sel_o) && $stable(column_power_on_o) &&
    $stable(integration_speed_sel_o) && $stable(feedback_cap_size_o) &&
    $stable(phase_swap_sel_o) && $stable(gain_sign_sel_o) && $stable(input_cap_code_o))
    else $error("unmapped access changed controls");

  reset_rest_a: assert property (@(posedge clock_i)
    rst_i |=> (phase_swap_sel_o == '0 && gain_sign_sel_o == '0 &&
               !pslverr_o && prdata_o == '0))
    else $error("switch selects or bus outputs not cleared after reset");

  hidden_slot_a: assert property (@(posedge clock_i) disable iff (rst_i)
    TYPE_E_MAP |-> (input_cap_code_o[0] == '0 && !feedback_cap_size_o[0] &&
                    !phase_swap_sel_o[0] && !gain_sign_sel_o[0]))
    else $error("hidden capacitor slot left its reset value");

endmodule // acc_regs

/* File: sim/testbench.sv */
// self-checking apb bench for the analog column configuration register bank
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // signals
  logic                    clock = 1'b0;
  logic                    rst = 1'b1;
  logic                    psel = 1'b0;
  logic                    penable = 1'b0;
  logic                    pwrite = 1'b0;
  logic [11:0]             paddr = 12'h000;
  logic [31:0]             pwdata = 32'h00000000;
  logic [3:0]              pstrb = 4'h0;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic [1:0]              rail;
  logic [1:0]              column_power_on;
  logic [1:0]              spd;
  logic [3:0]              feedback_cap_size;
  logic [3:0]              phs;
  logic [3:0]              sgn;
  logic [3:0][4:0]         input_cap_code;
  logic [37:0]             outs;
  logic [7:0]              sh [7] = '{default: 8'h00};
  int                      fail_count = 0;
  int                      n_tests = 0;
  // slots: ct c0, ct c1, se r1c0, se r1c1, sc r1c2, sc r2c1, sc r2c3
  localparam logic [6:0][11:0] ADR = {{acc_pkg::IDX_SC_R2C3, 2'b00},
    {acc_pkg::IDX_SC_R2C1, 2'b00}, {acc_pkg::IDX_SC_R1C2, 2'b00},
    {acc_pkg::IDX_SE_R1C1, 2'b00}, {acc_pkg::IDX_SE_R1C0, 2'b00},
    {acc_pkg::IDX_CT_C1, 2'b00}, {acc_pkg::IDX_CT_C0, 2'b00}};
  localparam logic [6:0][7:0] MSK = {8'hFF, 8'hFF, 8'hFF, 8'h80, 8'h80, 8'h03, 8'h03};
  assign outs = {rail, column_power_on, spd, feedback_cap_size, phs, sgn, input_cap_code};

  acc_regs #(.TYPE_E_MAP(1'b1)) uut (
    .clock_i(clock), .rst_i(rst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .rail_to_rail_sel_o(rail),
    .column_power_on_o(column_power_on), .integration_speed_sel_o(spd), .feedback_cap_size_o(feedback_cap_size),
    .phase_swap_sel_o(phs), .gain_sign_sel_o(sgn), .input_cap_code_o(input_cap_code));

  initial begin
    forever #2 clock = ~clock;
  end
  // ==========================================================================
  // tasks
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // apb transfer; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                      input logic [3:0] s, output logic [32:0] r);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    pstrb   <= s;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    r = {pslverr, prdata};
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // unreachable type c r1c0 (index 0) stays zero with the type e mapping
  function automatic logic [37:0] exp_outs();
    return {sh[1][1], sh[0][1], sh[1][0], sh[0][0], sh[3][7], sh[2][7],
            sh[6][7], sh[5][7], sh[4][7], 1'b0, sh[6][6], sh[5][6], sh[4][6], 1'b0,
            sh[6][5], sh[5][5], sh[4][5], 1'b0, sh[6][4:0], sh[5][4:0], sh[4][4:0], 5'h00};
  endfunction
  // ==========================================================================
  // tests
  initial begin
    logic [32:0] r;
    logic [7:0]  vals [4];
    vals = '{8'hFF, 8'hA5, 8'h5A, 8'h00};
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      xfer(1'b0, ADR[i], 8'h00, 4'h0, r);
      cmp({31'h0, r}, 64'h0);
    end
    cmp({26'h0, outs}, 64'h0);
    $display("test reset values done");
    foreach (vals[v]) begin
      for (int i = 0; i < 7; i++) begin
        xfer(1'b1, ADR[i], vals[v] & MSK[i], 4'h1, r);
        sh[i] = vals[v] & MSK[i];
        #1;
        cmp({26'h0, outs}, {26'h0, exp_outs()});
        xfer(1'b0, ADR[i], 8'h00, 4'h0, r);
        cmp({31'h0, r}, {56'h0, sh[i]});
      end
    end
    $display("test field write and readback done");
    xfer(1'b1, ADR[4], 8'hFF, 4'h0, r);
    xfer(1'b0, ADR[4], 8'h00, 4'h0, r);
    cmp({31'h0, r}, {56'h0, sh[4]});
    xfer(1'b1, 12'hFFC, 8'hFF, 4'h1, r);
    cmp({63'h0, r[32]}, 64'h1);
    xfer(1'b0, 12'h004, 8'h00, 4'h0, r);
    cmp({63'h0, r[32]}, 64'h1);
    #1;
    cmp({26'h0, outs}, {26'h0, exp_outs()});
    $display("test refused accesses done");
    xfer(1'b1, ADR[0], 8'h03, 4'h1, r);
    sh[0] = 8'h03;
    #1;
    cmp({26'h0, outs}, {26'h0, exp_outs()});
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    #1;
    cmp({26'h0, outs}, 64'h0);
    xfer(1'b0, ADR[0], 8'h00, 4'h0, r);
    cmp({31'h0, r}, 64'h0);
    $display("test mid-run reset done");
    finish_test();
  end

  initial begin
    #40000;
    fail_count++;
    finish_test();
  end
endmodule // testbench
